/* ppe_pkg.sv */
// Shared constants and types for the port pin block
package ppe_pkg;

    // Bus geometry
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int STRB_W = DATA_W / 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_OUT = 8'h00; // port_output_reg
    localparam logic [ADDR_W-1:0] OFF_DIR = 8'h04; // pin_direction_reg
    localparam logic [ADDR_W-1:0] OFF_REN = 8'h08; // pull_resistor_enable
    localparam logic [ADDR_W-1:0] OFF_SEL = 8'h0c; // pin_function_select
    localparam logic [ADDR_W-1:0] OFF_IN  = 8'h10; // port_input_reg
    localparam logic [ADDR_W-1:0] OFF_IES = 8'h14; // edge_select
    localparam logic [ADDR_W-1:0] OFF_IE  = 8'h18; // pin_interrupt_enable
    localparam logic [ADDR_W-1:0] OFF_IFG = 8'h1c; // pin_interrupt_flag

    // Reset values of the software registers
    localparam logic [DATA_W-1:0] RST_OUT = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_DIR = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_REN = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_SEL = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_IES = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_IE  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_IFG = 32'h0000_0000;

    // Bus response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One accepted register write
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [STRB_W-1:0] strb;
    } ppe_wreq_t;

    // Address decode; input and flag words are read only
    function automatic logic ppe_addr_mapped(input logic [ADDR_W-1:0] a,
                                             input logic wr);
        logic hit;
        hit = (a[1:0] == 2'h0) && (a <= OFF_IFG);
        if (wr && (a == OFF_IN || a == OFF_IFG)) begin
            hit = 1'b0;
        end
        return hit;
    endfunction

endpackage

/* ppe_axil_slave.sv */
`timescale 1ns/1ps
// AXI4-Lite slave front end, one write and one read in flight
module ppe_axil_slave
    import ppe_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Write address and data
    input  wire logic [ADDR_W-1:0] s_awaddr,
    input  wire logic              s_awvalid,
    output logic                   s_awready,
    input  wire logic [DATA_W-1:0] s_wdata,
    input  wire logic [STRB_W-1:0] s_wstrb,
    input  wire logic              s_wvalid,
    output logic                   s_wready,
    // Write response
    output logic [1:0]             s_bresp,
    output logic                   s_bvalid,
    input  wire logic              s_bready,
    // Read address and data
    input  wire logic [ADDR_W-1:0] s_araddr,
    input  wire logic              s_arvalid,
    output logic                   s_arready,
    output logic [DATA_W-1:0]      s_rdata,
    output logic [1:0]             s_rresp,
    output logic                   s_rvalid,
    input  wire logic              s_rready,
    // Register side
    output ppe_wreq_t              wr_req,
    output logic                   wr_stb,
    output logic [ADDR_W-1:0]      rd_addr,
    output logic                   rd_stb,
    input  wire logic [DATA_W-1:0] rd_data
);

    logic [ADDR_W-1:0] aw_addr_r;  // Held write address
    logic [DATA_W-1:0] w_data_r;   // Held write data
    logic [STRB_W-1:0] w_strb_r;   // Held byte strobes
    logic              awready_r;  // Address slot free
    logic              wready_r;   // Data slot free
    logic              bvalid_r;   // Response pending
    logic [1:0]        bresp_r;    // Response code
    logic              wr_stb_r;   // One cycle write pulse
    logic [ADDR_W-1:0] ar_addr_r;  // Held read address
    logic              arready_r;  // Read slot free
    logic              rd_pend_r;  // Read data being fetched
    logic              rvalid_r;   // Read data pending
    logic [1:0]        rresp_r;    // Read response code
    logic [DATA_W-1:0] rdata_r;    // Read data

    // Write path: address and data taken in either order
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_addr_r <= '0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            wr_stb_r  <= 1'b0;
        end else begin
            wr_stb_r <= 1'b0;
            if (s_awvalid && awready_r) begin
                aw_addr_r <= s_awaddr;
                awready_r <= 1'b0;
            end
            if (s_wvalid && wready_r) begin
                w_data_r <= s_wdata;
                w_strb_r <= s_wstrb;
                wready_r <= 1'b0;
            end
            // Both halves held: commit once and answer
            if (!awready_r && !wready_r && !bvalid_r) begin
                wr_stb_r <= ppe_addr_mapped(aw_addr_r, 1'b1);
                bvalid_r <= 1'b1;
                bresp_r  <= ppe_addr_mapped(aw_addr_r, 1'b1) ?
                            RESP_OKAY : RESP_SLVERR;
            end
            // Slots reopen only after the response is taken
            if (bvalid_r && s_bready) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // Read path: fetch one cycle after address, then answer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ar_addr_r <= '0;
            arready_r <= 1'b1;
            rd_pend_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= '0;
        end else begin
            if (s_arvalid && arready_r) begin
                ar_addr_r <= s_araddr;
                arready_r <= 1'b0;
                rd_pend_r <= 1'b1;
            end
            if (rd_pend_r) begin
                rdata_r   <= rd_data;
                rresp_r   <= ppe_addr_mapped(ar_addr_r, 1'b0) ?
                             RESP_OKAY : RESP_SLVERR;
                rvalid_r  <= 1'b1;
                rd_pend_r <= 1'b0;
            end
            if (rvalid_r && s_rready) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // Outputs straight from flops
    assign s_awready   = awready_r;
    assign s_wready    = wready_r;
    assign s_bvalid    = bvalid_r;
    assign s_bresp     = bresp_r;
    assign s_arready   = arready_r;
    assign s_rvalid    = rvalid_r;
    assign s_rresp     = rresp_r;
    assign s_rdata     = rdata_r;
    assign wr_req.addr = aw_addr_r;
    assign wr_req.data = w_data_r;
    assign wr_req.strb = w_strb_r;
    assign wr_stb      = wr_stb_r;
    assign rd_addr     = ar_addr_r;
    assign rd_stb      = rd_pend_r;

endmodule // ppe_axil_slave

/* ppe_pin_edge.sv */
`timescale 1ns/1ps
// One pin: input capture, clear hold and edge event
module ppe_pin_edge (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Pin side
    input  wire logic pin_level,
    input  wire logic power_up_clear,
    input  wire logic edge_select,
    // Port side
    output logic      in_bit,
    output logic      edge_evt
);

    logic in_r;      // Readable input bit
    logic in_d_r;    // Input bit one cycle back
    logic clr_q_r;   // Clear level aligned with in_r
    logic clr_qq_r;  // Clear level aligned with in_d_r
    logic rise;      // Low to high seen
    logic fall;      // High to low seen
    logic clr_cause; // Change was made by the clear

    // Input held at zero during clear, pin level after
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            in_r   <= 1'b0;
            in_d_r <= 1'b0;
        end else begin
            in_r   <= power_up_clear ? 1'b0 : pin_level;
            in_d_r <= in_r;
        end
    end

    // Clear level delayed to match the input pipe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clr_q_r  <= 1'b0;
            clr_qq_r <= 1'b0;
        end else begin
            clr_q_r  <= power_up_clear;
            clr_qq_r <= clr_q_r;
        end
    end

    assign rise      = in_r & ~in_d_r;
    assign fall      = ~in_r & in_d_r;
    assign clr_cause = clr_q_r ^ clr_qq_r;

    // Clear-made edges flag whatever edge_select says
    assign edge_evt = (edge_select ? fall : rise) |
                      ((rise | fall) & clr_cause);
    assign in_bit   = in_r;

endmodule // ppe_pin_edge

/* ppe_port.sv */
`timescale 1ns/1ps
// Operation
// - Pull plus peripheral: pull follows peripheral output
// - Clear holds input register at zero
// - Clear makes falling then rising input edges
// - Clear-made edges set flags regardless of edge_select
module ppe_port
    import ppe_pkg::*;
#(
    parameter int N_PINS = 8 // Pins in this port
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_awaddr,
    input  wire logic              s_awvalid,
    output logic                   s_awready,
    // AXI4-Lite write data
    input  wire logic [DATA_W-1:0] s_wdata,
    input  wire logic [STRB_W-1:0] s_wstrb,
    input  wire logic              s_wvalid,
    output logic                   s_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_bresp,
    output logic                   s_bvalid,
    input  wire logic              s_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_araddr,
    input  wire logic              s_arvalid,
    output logic                   s_arready,
    // AXI4-Lite read data
    output logic [DATA_W-1:0]      s_rdata,
    output logic [1:0]             s_rresp,
    output logic                   s_rvalid,
    input  wire logic              s_rready,
    // System clear
    input  wire logic              power_up_clear,
    // Pad side
    input  wire logic [N_PINS-1:0] pin_in,
    output logic [N_PINS-1:0]      pin_out,
    output logic [N_PINS-1:0]      pin_oe_n,
    output logic [N_PINS-1:0]      pull_en,
    output logic [N_PINS-1:0]      pull_up,
    // Peripheral side
    input  wire logic [N_PINS-1:0] periph_out,
    input  wire logic [N_PINS-1:0] periph_dir,
    // Interrupt
    output logic                   irq
);

    // Reject widths the zero-extension cannot serve
    if (N_PINS < 1 || N_PINS > DATA_W - 1) begin : g_bad_width
        $error("ppe_port: N_PINS must be 1 to 31");
    end

    // Software registers
    logic [N_PINS-1:0] port_output_reg_r;      // Pin drive value
    logic [N_PINS-1:0] pin_direction_reg_r;    // One drives the pin
    logic [N_PINS-1:0] pull_resistor_enable_r; // Pull resistor on
    logic [N_PINS-1:0] pin_function_select_r;  // Peripheral owns pin
    logic [N_PINS-1:0] edge_select_r;          // One picks falling edge
    logic [N_PINS-1:0] pin_interrupt_enable_r; // Interrupt mask
    logic [N_PINS-1:0] pin_interrupt_flag_r;   // Sticky edge flags
    logic [N_PINS-1:0] pin_interrupt_flag_nxt; // Next flag value

    // Pad output flops
    logic [N_PINS-1:0] pin_out_r;  // Driven level
    logic [N_PINS-1:0] pin_oe_n_r; // Low while driving
    logic [N_PINS-1:0] pull_en_r;  // Pull resistor active
    logic [N_PINS-1:0] pull_up_r;  // One pulls up, zero pulls down
    logic              irq_r;      // Level interrupt

    // Per-pin results
    logic [N_PINS-1:0] port_input_reg; // Captured pin levels
    logic [N_PINS-1:0] edge_evt;       // Edge events this cycle

    // Bus side signals
    ppe_wreq_t         wr_req;  // Accepted write
    logic              wr_stb;  // Write commit pulse
    logic [ADDR_W-1:0] rd_addr; // Read address
    logic              rd_stb;  // Read fetch pulse
    logic [DATA_W-1:0] rd_data; // Read word
    logic [N_PINS-1:0] wmask;   // Per-bit write enable
    logic [N_PINS-1:0] wdata;   // Write data for this port

    // Pad control derived from registers
    logic [N_PINS-1:0] drive_src; // Value before the pad flop
    logic [N_PINS-1:0] dir_src;   // Direction before the pad flop
    logic [N_PINS-1:0] pull_dir;  // Pull direction before the flop
    logic [N_PINS-1:0] periph_pull; // Pins where peripheral steers pull

    // Bus front end
    ppe_axil_slave u_bus (
        .clk       (clk),
        .rstn      (rstn),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .wr_req    (wr_req),
        .wr_stb    (wr_stb),
        .rd_addr   (rd_addr),
        .rd_stb    (rd_stb),
        .rd_data   (rd_data)
    );

    // Per-pin capture and edge logic, plus byte lane mask
    for (genvar i = 0; i < N_PINS; i++) begin : g_pin
        ppe_pin_edge u_edge (
            .clk            (clk),
            .rstn           (rstn),
            .pin_level      (pin_in[i]),
            .power_up_clear (power_up_clear),
            .edge_select    (edge_select_r[i]),
            .in_bit         (port_input_reg[i]),
            .edge_evt       (edge_evt[i])
        );
        assign wmask[i] = wr_req.strb[i / 8];
    end

    assign wdata = wr_req.data[N_PINS-1:0];

    // Byte-lane merge of a write into a register
    function automatic logic [N_PINS-1:0] merge(
        input logic [N_PINS-1:0] old,
        input logic [N_PINS-1:0] nw,
        input logic [N_PINS-1:0] m
    );
        return (old & ~m) | (nw & m);
    endfunction

    // Zero-extend a port-wide value onto the bus
    function automatic logic [DATA_W-1:0] zx(input logic [N_PINS-1:0] v);
        return {{(DATA_W - N_PINS){1'b0}}, v};
    endfunction

    // Configuration registers written by software
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            port_output_reg_r      <= RST_OUT[N_PINS-1:0];
            pin_direction_reg_r    <= RST_DIR[N_PINS-1:0];
            pull_resistor_enable_r <= RST_REN[N_PINS-1:0];
            pin_function_select_r  <= RST_SEL[N_PINS-1:0];
            edge_select_r          <= RST_IES[N_PINS-1:0];
            pin_interrupt_enable_r <= RST_IE[N_PINS-1:0];
        end else if (wr_stb) begin
            // Unmapped and read-only words never raise wr_stb
            unique case (wr_req.addr)
                OFF_OUT: begin
                    port_output_reg_r <=
                        merge(port_output_reg_r, wdata, wmask);
                end
                OFF_DIR: begin
                    pin_direction_reg_r <=
                        merge(pin_direction_reg_r, wdata, wmask);
                end
                OFF_REN: begin
                    pull_resistor_enable_r <=
                        merge(pull_resistor_enable_r, wdata, wmask);
                end
                OFF_SEL: begin
                    pin_function_select_r <=
                        merge(pin_function_select_r, wdata, wmask);
                end
                OFF_IES: begin
                    edge_select_r <= merge(edge_select_r, wdata, wmask);
                end
                OFF_IE: begin
                    // Stale flags fire at once; software clears first
                    pin_interrupt_enable_r <=
                        merge(pin_interrupt_enable_r, wdata, wmask);
                end
                default: begin
                    // No other writable word
                end
            endcase
        end
    end

    // Flags: a read clears them, a new edge in that cycle survives
    always_comb begin
        pin_interrupt_flag_nxt = pin_interrupt_flag_r;
        if (rd_stb && rd_addr == OFF_IFG) begin
            pin_interrupt_flag_nxt = '0;
        end
        pin_interrupt_flag_nxt = pin_interrupt_flag_nxt | edge_evt;
    end

    // Flag storage; the clear input does not wipe it on purpose
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_interrupt_flag_r <= RST_IFG[N_PINS-1:0];
        end else begin
            pin_interrupt_flag_r <= pin_interrupt_flag_nxt;
        end
    end

    // Read mux; the flag word returns the value before clearing
    always_comb begin
        unique case (rd_addr)
            OFF_OUT: rd_data = zx(port_output_reg_r);
            OFF_DIR: rd_data = zx(pin_direction_reg_r);
            OFF_REN: rd_data = zx(pull_resistor_enable_r);
            OFF_SEL: rd_data = zx(pin_function_select_r);
            OFF_IN:  rd_data = zx(port_input_reg);
            OFF_IES: rd_data = zx(edge_select_r);
            OFF_IE:  rd_data = zx(pin_interrupt_enable_r);
            OFF_IFG: rd_data = zx(pin_interrupt_flag_r);
            default: rd_data = '0;
        endcase
    end

    // Pad source selection between port and peripheral
    assign periph_pull = pull_resistor_enable_r & pin_function_select_r;
    assign drive_src   = (pin_function_select_r & periph_out) |
                         (~pin_function_select_r & port_output_reg_r);
    assign dir_src     = (pin_function_select_r & periph_dir) |
                         (~pin_function_select_r & pin_direction_reg_r);
    // Pull direction; peripheral output wins when it owns the pin with its pull enabled
    assign pull_dir    = (periph_pull & periph_out) |
                         (~periph_pull & port_output_reg_r);

    // Pad flops; a driven pin never has its pull on
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_out_r  <= '0;
            pin_oe_n_r <= '1;
            pull_en_r  <= '0;
            pull_up_r  <= '0;
        end else begin
            pin_out_r  <= drive_src;
            pin_oe_n_r <= ~dir_src;
            pull_en_r  <= pull_resistor_enable_r & ~dir_src;
            pull_up_r  <= pull_dir;
        end
    end

    // Interrupt level, one cycle behind the flags
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(pin_interrupt_flag_r & pin_interrupt_enable_r);
        end
    end

    // Top outputs from flops
    assign pin_out  = pin_out_r;
    assign pin_oe_n = pin_oe_n_r;
    assign pull_en  = pull_en_r;
    assign pull_up  = pull_up_r;
    assign irq      = irq_r;

endmodule // ppe_port

/* ppe_port_properties.sv */
`timescale 1ns/1ps
// Bus and pad checks seen from the port block's pins
module ppe_port_properties
    import ppe_pkg::*;
#(
    parameter int N_PINS = 8 // Pins in this port
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    // Bus handshakes
    input wire logic              s_awvalid,
    input wire logic              s_awready,
    input wire logic              s_wvalid,
    input wire logic              s_wready,
    input wire logic [1:0]        s_bresp,
    input wire logic              s_bvalid,
    input wire logic              s_bready,
    input wire logic              s_arvalid,
    input wire logic              s_arready,
    input wire logic [DATA_W-1:0] s_rdata,
    input wire logic              s_rvalid,
    input wire logic              s_rready,
    // Pads and interrupt
    input wire logic [N_PINS-1:0] pin_oe_n,
    input wire logic [N_PINS-1:0] pull_en,
    input wire logic              irq
);
    // One domain only
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_reset_idle: assert property (!$past(rstn) |->
        pin_oe_n == '1 && !irq && !s_bvalid && !s_rvalid)
        else $error("outputs not idle after reset");
    chk_write_answer: assert property (s_awvalid && s_awready &&
        s_wvalid && s_wready |-> ##2 s_bvalid)
        else $error("write response late");
    chk_write_busy: assert property ($rose(s_bvalid) |->
        !s_awready && !s_wready) else $error("write slot open early");
    chk_bresp_hold: assert property (s_bvalid && !s_bready |=>
        s_bvalid && $stable(s_bresp)) else $error("write response dropped");
    chk_b_release: assert property (s_bvalid && s_bready |=>
        !s_bvalid ##[0:1] s_awready) else $error("write slot not reopened");
    chk_read_answer: assert property (s_arvalid && s_arready |=>
        !s_arready ##1 s_rvalid) else $error("read data late");
    chk_rdata_hold: assert property (s_rvalid && !s_rready |=>
        s_rvalid && $stable(s_rdata)) else $error("read data dropped");
    // A pull on a driven pad would fight the driver
    chk_pull_released: assert property ((pull_en & ~pin_oe_n) == '0)
        else $error("pull on while pad driven");

    cover property (s_bvalid && s_bready && s_bresp == RESP_SLVERR);
    cover property ($rose(irq));
    cover property (pull_en != '0);
endmodule // ppe_port_properties

bind ppe_port ppe_port_properties #(.N_PINS(N_PINS)) u_props (
    .clk, .rstn, .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rdata, .s_rvalid,
    .s_rready, .pin_oe_n, .pull_en, .irq);

/* ppe_pad_model.sv */
`timescale 1ns/1ps
// Pads: device drive, then far-end drive, then weak pull
module ppe_pad_model #(
    parameter int N_PINS = 8 // Pins in this port
) (
    // Clock
    input  wire logic              clk,
    // Device pad outputs
    input  wire logic [N_PINS-1:0] pin_out,
    input  wire logic [N_PINS-1:0] pin_oe_n,
    input  wire logic [N_PINS-1:0] pull_en,
    input  wire logic [N_PINS-1:0] pull_up,
    // Far-end driver
    input  wire logic [N_PINS-1:0] ext_lvl,
    input  wire logic [N_PINS-1:0] ext_en,
    // Level seen by the device
    output logic [N_PINS-1:0]      pin_in
);
    initial pin_in = '0;
    // A floating pad toggles, so no stale level can pass for a pull
    always @(posedge clk) begin
        for (int i = 0; i < N_PINS; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] <= pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] <= ext_lvl[i];
            end else if (pull_en[i]) begin
                pin_in[i] <= pull_up[i];
            end else begin
                pin_in[i] <= ~pin_in[i];
            end
        end
    end
endmodule // ppe_pad_model

/* test_port_pin_pull_and_edge_flags.sv */
`timescale 1ns/1ps
// Self-checking bench for the port pin block
module test_port_pin_pull_and_edge_flags
    import ppe_pkg::*;
;
    logic clk, rstn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
    logic s_bready, s_arvalid, s_arready, s_rvalid, s_rready, irq, clr;
    logic [7:0] s_awaddr, s_araddr, pin_in, pin_out, pin_oe_n, pull_en;
    logic [7:0] pull_up, periph_out, periph_dir, ext_lvl, ext_en;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp;
    int miscompares, checked;

    ppe_port #(.N_PINS(8)) dut (
        .clk, .rstn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
        .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
        .power_up_clear(clr), .pin_in, .pin_out, .pin_oe_n, .pull_en,
        .pull_up, .periph_out, .periph_dir, .irq);
    ppe_pad_model #(.N_PINS(8)) u_pads (
        .clk, .pin_out, .pin_oe_n, .pull_en, .pull_up, .ext_lvl, .ext_en,
        .pin_in);

    // 40 MHz clock
    always #12.5 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] exp, got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Write: address and data offered together, bready held until answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] rs);
        @(posedge clk);
        s_awaddr <= a;
        s_awvalid <= 1'b1;
        s_wdata <= d;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) begin
                s_bready <= 1'b0;
                chk("bresp", {30'h0, rs}, {30'h0, s_bresp});
                break;
            end
        end
    endtask

    // Read; cmp low skips the data compare to drain a read-clear word, rresp is still checked
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] rs, input logic cmp);
        @(posedge clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) begin
                s_rready <= 1'b0;
                if (cmp) chk("rdata", exp, s_rdata);
                chk("rresp", {30'h0, rs}, {30'h0, s_rresp});
                break;
            end
        end
    endtask

    task automatic t_reset_map;
        logic [31:0] rv [8];
        rv = '{RST_OUT, RST_DIR, RST_REN, RST_SEL, 32'h0, RST_IES, RST_IE,
               RST_IFG};
        for (int i = 0; i < 8; i++) rd(8'(i * 4), rv[i], RESP_OKAY, 1'b1);
        rd(8'h20, 32'h0, RESP_SLVERR, 1'b1);
        rd(8'h02, 32'h0, RESP_SLVERR, 1'b1);
        wr(OFF_IN, 32'hff, RESP_SLVERR);
        wr(OFF_IFG, 32'hff, RESP_SLVERR);
    endtask

    task automatic t_pull_port;
        wr(OFF_REN, 32'hff, RESP_OKAY);
        wr(OFF_OUT, 32'h5a, RESP_OKAY);
        ext_en <= 8'h00;
        repeat (6) @(posedge clk);
        rd(OFF_IN, 32'h5a, RESP_OKAY, 1'b1);
        wr(OFF_DIR, 32'hff, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("oe_n", 32'h0, {24'h0, pin_oe_n});
        chk("pin_out", 32'h5a, {24'h0, pin_out});
        wr(OFF_DIR, 32'h00, RESP_OKAY);
    endtask

    task automatic t_pull_periph;
        periph_out <= 8'hc3;
        wr(OFF_SEL, 32'hff, RESP_OKAY);
        repeat (6) @(posedge clk);
        rd(OFF_IN, 32'hc3, RESP_OKAY, 1'b1);
        periph_dir <= 8'hff;
        repeat (3) @(posedge clk);
        chk("periph pin_out", 32'hc3, {24'h0, pin_out});
        periph_dir <= 8'h00;
        ext_en <= 8'hff;
        wr(OFF_SEL, 32'h00, RESP_OKAY);
        wr(OFF_REN, 32'h00, RESP_OKAY);
    endtask

    task automatic t_clear_flags;
        ext_lvl <= 8'hf0;
        wr(OFF_IES, 32'h00, RESP_OKAY);
        repeat (6) @(posedge clk);
        rd(OFF_IFG, 32'h0, RESP_OKAY, 1'b0);
        wr(OFF_IE, 32'hf0, RESP_OKAY);
        clr <= 1'b1;
        repeat (6) @(posedge clk);
        rd(OFF_IN, 32'h0, RESP_OKAY, 1'b1);
        chk("irq", 32'h1, {31'h0, irq});
        rd(OFF_IFG, 32'hf0, RESP_OKAY, 1'b1);
        repeat (2) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        wr(OFF_IES, 32'hff, RESP_OKAY);
        wr(OFF_IE, 32'h00, RESP_OKAY);
        clr <= 1'b0;
        repeat (6) @(posedge clk);
        rd(OFF_IN, 32'hf0, RESP_OKAY, 1'b1);
        chk("masked irq", 32'h0, {31'h0, irq});
        rd(OFF_IFG, 32'hf0, RESP_OKAY, 1'b1);
        ext_lvl <= 8'hf1;
        repeat (6) @(posedge clk);
        rd(OFF_IFG, 32'h0, RESP_OKAY, 1'b1);
        ext_lvl <= 8'hf0;
        repeat (6) @(posedge clk);
        rd(OFF_IFG, 32'h1, RESP_OKAY, 1'b1);
    endtask

    task automatic conclude;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {clk, rstn, s_awvalid, s_wvalid, s_bready, s_arvalid} = '0;
        {s_rready, clr, s_awaddr, s_araddr, s_wdata} = '0;
        {periph_out, periph_dir, ext_lvl} = '0;
        s_wstrb = 4'hf;
        ext_en = 8'hff;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_reset_map();
        t_pull_port();
        t_pull_periph();
        t_clear_flags();
        conclude();
    end

    // Watchdog, far past the run's length
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule // test_port_pin_pull_and_edge_flags
